// ===== hdl/adc_ctrl.v
// Converter control: serial register port, pin functions, averaging sequencer and check codes.
//
// Behaviour
// - Reset makes all eight channels analog inputs.
// - Per-channel analog or pin; pin direction per bit.
// - Read input levels; written levels drive outputs.
// - Output drive open-drain or push-pull per bit.
// - External reference default; control bit enables internal.
// - Straight binary results; range bit doubles span.
// - Calibration bit starts calibration, clears when done.
// - Nonzero three-bit factor enables averaging, all channels.
// - Averaged 20-bit result readable only when complete.
// - Host starts first conversion; rest generated internally.
// - Averaging time is samples times sampling period.
// - Autonomous mode averages enabled channels in sequence.
// - Checking only when enabled; payload one to three bytes.
// - Check byte: poly 0x107, preset all ones.
// - Mismatch: command dropped, inbound error flag set.
// - With error only checked writes to 0x00/0x01.
// - With error reads and data reads still served.
// - Error shown in status register and status trailer.
// - Responses carry check byte over response payload.
// - Trailer: one, fixed-voltage, check error, bit-walk.
`timescale 1ns/1ps
`include "adc_ctrl_consts.vh"

module adc_ctrl (
  // Clock and reset
  input wire clk_sys,
  input wire rst_b,
  // Serial port
  input wire cs_b,
  input wire sclk,
  input wire sdi,
  output wire sdo,
  output wire sdo_oe,
  // Channel pins
  input wire [7:0] gpio_in,
  output wire [7:0] gpio_out,
  output wire [7:0] gpio_oe,
  output wire [7:0] ain_select,
  // Analog front end
  output wire ref_internal_en,
  output wire range_double,
  output reg conv_start,
  output reg [2:0] conv_channel,
  input wire [15:0] conv_code,
  input wire conv_done,
  output reg cal_start,
  input wire cal_done,
  // Diagnostic state
  input wire vtest_active,
  input wire bitwalk_active
);

  localparam ST_IDLE = 3'b001;
  localparam ST_CONV = 3'b010;
  localparam ST_WAIT = 3'b100;

  // ==========================================================
  // Input synchronisers and edge detection
  reg [2:0] cs_sync_r;
  reg [2:0] sclk_sync_r;
  reg [1:0] sdi_sync_r;
  reg [7:0] gpio_meta_r;
  reg [7:0] gpio_sync_r;

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      cs_sync_r <= 3'h7;
      sclk_sync_r <= 3'h0;
      sdi_sync_r <= 2'h0;
      gpio_meta_r <= 8'h00;
      gpio_sync_r <= 8'h00;
    end else begin
      cs_sync_r <= {cs_sync_r[1:0], cs_b};
      sclk_sync_r <= {sclk_sync_r[1:0], sclk};
      sdi_sync_r <= {sdi_sync_r[0], sdi};
      gpio_meta_r <= gpio_in;
      gpio_sync_r <= gpio_meta_r;
    end
  end

  wire cs_low = ~cs_sync_r[1];
  wire frame_start = cs_sync_r[2] & ~cs_sync_r[1];
  wire frame_end = ~cs_sync_r[2] & cs_sync_r[1];
  wire sclk_rise = ~sclk_sync_r[2] & sclk_sync_r[1];
  wire sclk_fall = sclk_sync_r[2] & ~sclk_sync_r[1];

  // ==========================================================
  // Registers
  reg [7:0] gen_ctrl_r;
  reg check_err_r;
  reg [1:0] trailer_sel_r;
  reg [3:0] clk_div_r;
  reg [2:0] avg_factor_r;
  reg [7:0] chan_func_r;
  reg [7:0] pin_dir_r;
  reg [7:0] drive_type_r;
  reg [7:0] out_level_r;
  reg [1:0] seq_mode_r;
  reg [2:0] manual_ch_r;
  reg [7:0] seq_enable_r;
  reg soft_rst_r;
  reg [2:0] st_r;

  // A software reset returns configuration to defaults but leaves the serial shifter alone.
  wire cfg_rst = ~rst_b | soft_rst_r;
  wire check_en = gen_ctrl_r[`GC_CHECK_EN];
  wire [7:0] in_levels = gpio_sync_r & chan_func_r & ~pin_dir_r;

  // ==========================================================
  // Inbound frame
  reg [31:0] rx_r;
  reg [5:0] rx_cnt_r;

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      rx_r <= 32'h00000000;
      rx_cnt_r <= 6'h00;
    end else if (frame_start) begin
      rx_cnt_r <= 6'h00;
    end else if (cs_low && sclk_rise) begin
      rx_r <= {rx_r[30:0], sdi_sync_r[1]};
      if (rx_cnt_r != 6'h3F) begin
        rx_cnt_r <= rx_cnt_r + 6'h01;
      end
    end
  end

  wire [23:0] cmd = check_en ? rx_r[31:8] : rx_r[23:0];
  wire [7:0] cmd_crc;
  crc8_calc u_rx_crc (
    .data(rx_r[31:8]),
    .nbytes(2'h3),
    .crc(cmd_crc)
  );

  wire plain_ok = ~check_en & (rx_cnt_r == 6'h18);
  wire checked_frame = check_en & (rx_cnt_r == 6'h20);
  wire crc_ok = checked_frame & (cmd_crc == rx_r[7:0]);
  wire crc_bad = frame_end & checked_frame & (cmd_crc != rx_r[7:0]);
  wire cmd_valid = frame_end & (plain_ok | crc_ok);
  wire [7:0] cmd_op = cmd[23:16];
  wire [7:0] cmd_addr = cmd[15:8];
  wire [7:0] cmd_data = cmd[7:0];
  wire addr_open = (cmd_addr == `ADDR_SYSTEM_STATE) | (cmd_addr == `ADDR_GENERAL_CONTROL);
  wire wr_en = cmd_valid & (cmd_op == `OP_WRITE) & (~check_err_r | addr_open);
  wire rd_en = cmd_valid & (cmd_op == `OP_READ);

  // ==========================================================
  // Register writes
  always @(posedge clk_sys) begin
    if (cfg_rst) begin
      gen_ctrl_r <= `RST_GENERAL_CONTROL;
      check_err_r <= 1'b0;
      trailer_sel_r <= `TRAILER_NONE;
      clk_div_r <= `RST_CLOCK_DIV;
      avg_factor_r <= 3'h0;
      chan_func_r <= `RST_CHANNEL_FUNCTION;
      pin_dir_r <= `RST_BYTE;
      drive_type_r <= `RST_BYTE;
      out_level_r <= `RST_BYTE;
      seq_mode_r <= `MODE_MANUAL;
      manual_ch_r <= 3'h0;
      seq_enable_r <= `RST_BYTE;
      soft_rst_r <= 1'b0;
      cal_start <= 1'b0;
    end else begin
      soft_rst_r <= 1'b0;
      cal_start <= 1'b0;
      if (cal_done) begin
        gen_ctrl_r[`GC_CAL] <= 1'b0;
      end
      // A new mismatch outranks a clear arriving in the same cycle.
      if (crc_bad) begin
        check_err_r <= 1'b1;
      end else if (wr_en && cmd_addr == `ADDR_SYSTEM_STATE && cmd_data[`SS_CHECK_ERR]) begin
        check_err_r <= 1'b0;
      end
      if (wr_en) begin
        case (cmd_addr)
          `ADDR_GENERAL_CONTROL: begin
            gen_ctrl_r[7:2] <= cmd_data[7:2];
            soft_rst_r <= cmd_data[`GC_SW_RESET];
            if (cmd_data[`GC_CAL] && !gen_ctrl_r[`GC_CAL]) begin
              gen_ctrl_r[`GC_CAL] <= 1'b1;
              cal_start <= 1'b1;
            end
          end
          `ADDR_DATA_CONFIG: trailer_sel_r <= cmd_data[5:4];
          `ADDR_CLOCK_CONFIG: clk_div_r <= cmd_data[3:0];
          `ADDR_AVERAGING_CONTROL: avg_factor_r <= cmd_data[2:0];
          `ADDR_CHANNEL_FUNCTION: chan_func_r <= cmd_data;
          `ADDR_PIN_DIRECTION: pin_dir_r <= cmd_data;
          `ADDR_OUTPUT_DRIVE_TYPE: drive_type_r <= cmd_data;
          `ADDR_PIN_OUTPUT_LEVELS: out_level_r <= cmd_data;
          `ADDR_SEQUENCE_MODE: seq_mode_r <= cmd_data[1:0];
          `ADDR_MANUAL_CHANNEL: manual_ch_r <= cmd_data[2:0];
          `ADDR_SEQUENCE_CHANNEL_ENABLES: seq_enable_r <= cmd_data;
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Register reads
  reg [7:0] rd_mux;
  always @* begin
    case (cmd_addr)
      `ADDR_SYSTEM_STATE: rd_mux = {5'h00, gen_ctrl_r[`GC_CAL], ~st_r[0], check_err_r};
      `ADDR_GENERAL_CONTROL: rd_mux = gen_ctrl_r;
      `ADDR_DATA_CONFIG: rd_mux = {2'h0, trailer_sel_r, 4'h0};
      `ADDR_CLOCK_CONFIG: rd_mux = {4'h0, clk_div_r};
      `ADDR_AVERAGING_CONTROL: rd_mux = {5'h00, avg_factor_r};
      `ADDR_CHANNEL_FUNCTION: rd_mux = chan_func_r;
      `ADDR_PIN_DIRECTION: rd_mux = pin_dir_r;
      `ADDR_OUTPUT_DRIVE_TYPE: rd_mux = drive_type_r;
      `ADDR_PIN_OUTPUT_LEVELS: rd_mux = out_level_r;
      `ADDR_PIN_INPUT_LEVELS: rd_mux = in_levels;
      `ADDR_SEQUENCE_MODE: rd_mux = {6'h00, seq_mode_r};
      `ADDR_MANUAL_CHANNEL: rd_mux = {5'h00, manual_ch_r};
      `ADDR_SEQUENCE_CHANNEL_ENABLES: rd_mux = seq_enable_r;
      default: rd_mux = 8'h00;
    endcase
  end

  // A read answers in the following frame; any other frame, valid or not, releases it.
  reg rd_pend_r;
  reg [7:0] rd_data_r;
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      rd_pend_r <= 1'b0;
      rd_data_r <= 8'h00;
    end else if (rd_en) begin
      rd_pend_r <= 1'b1;
      rd_data_r <= rd_mux;
    end else if (frame_end) begin
      rd_pend_r <= 1'b0;
    end
  end

  // ==========================================================
  // Channel pins
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : pin
      wire drives = chan_func_r[g] & pin_dir_r[g];
      // Open-drain pins only ever pull low; the high level comes from the board.
      assign gpio_oe[g] = drives & (drive_type_r[g] | ~out_level_r[g]);
      assign gpio_out[g] = drives & drive_type_r[g] & out_level_r[g];
    end
  endgenerate

  assign ain_select = ~chan_func_r;
  assign ref_internal_en = gen_ctrl_r[`GC_INT_REF];
  assign range_double = gen_ctrl_r[`GC_RANGE];

  // ==========================================================
  // Conversion and averaging sequencer
  reg [7:0] left_r;
  reg [22:0] acc_r;
  reg [10:0] gap_r;
  reg [19:0] result_r;
  reg [2:0] result_ch_r;
  reg result_avg_r;
  reg [2:0] next_ch;

  always @* begin : find_next
    integer k;
    next_ch = conv_channel;
    for (k = 7; k >= 1; k = k - 1) begin
      if (seq_enable_r[(conv_channel + k) % 8]) begin
        next_ch = conv_channel + k[2:0];
      end
    end
    if (!seq_enable_r[next_ch]) begin
      next_ch = conv_channel;
    end
  end

  wire autonomous = (seq_mode_r == `MODE_AUTONOMOUS);
  wire [31:0] period_full = `SAMPLE_BASE_CYC * ({28'h0000000, clk_div_r} + 32'h00000001);
  wire begin_avg = st_r[0] & ((frame_end & ~autonomous) | (autonomous & (seq_enable_r != 8'h00)));
  wire [2:0] first_ch = (seq_mode_r == `MODE_MANUAL) ? manual_ch_r : next_ch;
  wire [10:0] period = period_full[10:0];
  wire [22:0] acc_sum = acc_r + {7'h00, conv_code};
  wire [26:0] avg_wide = {acc_sum, 4'h0} >> avg_factor_r;

  always @(posedge clk_sys) begin
    if (cfg_rst) begin
      st_r <= ST_IDLE;
      conv_start <= 1'b0;
      conv_channel <= 3'h0;
      left_r <= 8'h00;
      acc_r <= 23'h000000;
      gap_r <= 11'h000;
      result_r <= 20'h00000;
      result_ch_r <= 3'h0;
      result_avg_r <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      if (gap_r != 11'h000) begin
        gap_r <= gap_r - 11'h001;
      end
      case (st_r)
        ST_IDLE: begin
          if (begin_avg) begin
            conv_start <= 1'b1;
            conv_channel <= first_ch;
            left_r <= 8'h01 << avg_factor_r;
            acc_r <= 23'h000000;
            gap_r <= period - 11'h001;
            st_r <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (conv_done) begin
            acc_r <= acc_sum;
            if (left_r == 8'h01) begin
              // The result is updated only once the whole average is in.
              result_r <= avg_wide[19:0];
              result_ch_r <= conv_channel;
              result_avg_r <= (avg_factor_r != 3'h0);
              st_r <= ST_IDLE;
            end else begin
              left_r <= left_r - 8'h01;
              st_r <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          if (gap_r == 11'h000) begin
            conv_start <= 1'b1;
            gap_r <= period - 11'h001;
            st_r <= ST_CONV;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Response payload and outbound shifter
  wire [3:0] status_nib = {1'b1, vtest_active, check_err_r, bitwalk_active};
  wire [3:0] trailer = (trailer_sel_r == `TRAILER_STATUS) ? status_nib : {1'b0, result_ch_r};
  wire has_trailer = (trailer_sel_r == `TRAILER_STATUS) | (trailer_sel_r == `TRAILER_CHAN);
  reg [23:0] resp;
  reg [1:0] resp_len;

  always @* begin
    if (rd_pend_r) begin
      resp = {rd_data_r, 16'h0000};
      resp_len = 2'h1;
    end else if (result_avg_r) begin
      resp = {result_r, has_trailer ? trailer : 4'h0};
      resp_len = 2'h3;
    end else if (has_trailer) begin
      resp = {result_r[19:4], trailer, 4'h0};
      resp_len = 2'h3;
    end else begin
      resp = {result_r[19:4], 8'h00};
      resp_len = 2'h2;
    end
  end

  wire [7:0] resp_crc_raw;
  crc8_calc u_tx_crc (
    .data(resp),
    .nbytes(resp_len),
    .crc(resp_crc_raw)
  );
  wire [7:0] resp_crc = check_en ? resp_crc_raw : 8'h00;

  reg [31:0] tx_r;
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      tx_r <= 32'h00000000;
    end else if (frame_start) begin
      case (resp_len)
        2'h1: tx_r <= {resp[23:16], resp_crc, 16'h0000};
        2'h2: tx_r <= {resp[23:8], resp_crc, 8'h00};
        default: tx_r <= {resp, resp_crc};
      endcase
    end else if (cs_low && sclk_fall) begin
      tx_r <= {tx_r[30:0], 1'b0};
    end
  end

  assign sdo = tx_r[31];
  assign sdo_oe = cs_low;

endmodule

// ===== hdl/adc_ctrl_consts.vh
// Register map, field positions, reset values and timing counts of the converter control block.
`ifndef ADC_CTRL_CONSTS_VH
`define ADC_CTRL_CONSTS_VH

// ==========================================================
// Register offsets
`define ADDR_SYSTEM_STATE 8'h00
`define ADDR_GENERAL_CONTROL 8'h01
`define ADDR_DATA_CONFIG 8'h02
`define ADDR_CLOCK_CONFIG 8'h03
`define ADDR_AVERAGING_CONTROL 8'h04
`define ADDR_CHANNEL_FUNCTION 8'h05
`define ADDR_PIN_DIRECTION 8'h07
`define ADDR_OUTPUT_DRIVE_TYPE 8'h09
`define ADDR_PIN_OUTPUT_LEVELS 8'h0B
`define ADDR_PIN_INPUT_LEVELS 8'h0D
`define ADDR_SEQUENCE_MODE 8'h10
`define ADDR_MANUAL_CHANNEL 8'h11
`define ADDR_SEQUENCE_CHANNEL_ENABLES 8'h12

// ==========================================================
// Frame opcodes
`define OP_NOP 8'h00
`define OP_WRITE 8'h08
`define OP_READ 8'h10

// ==========================================================
// Field positions
`define SS_CHECK_ERR 0
`define SS_AVG_BUSY 1
`define SS_CAL_BUSY 2
`define GC_SW_RESET 0
`define GC_CAL 1
`define GC_CHECK_EN 2
`define GC_RANGE 3
`define GC_INT_REF 7
`define TRAILER_NONE 2'h0
`define TRAILER_CHAN 2'h1
`define TRAILER_STATUS 2'h2
`define MODE_MANUAL 2'h0
`define MODE_AUTO 2'h1
`define MODE_AUTONOMOUS 2'h2

// ==========================================================
// Reset values
`define RST_GENERAL_CONTROL 8'h00
`define RST_CHANNEL_FUNCTION 8'h00
`define RST_BYTE 8'h00
`define RST_CLOCK_DIV 4'h4

// ==========================================================
// Check code
`define CRC_POLY 8'h07
`define CRC_PRESET 8'hFF

// ==========================================================
// Timing
`define CLK_PERIOD_NS 40
`define SAMPLE_BASE_NS 1000
`define SAMPLE_BASE_CYC ((`SAMPLE_BASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== hdl/crc8_calc.v
// Combinational 8-bit check code over one to three payload bytes.
`timescale 1ns/1ps
`include "adc_ctrl_consts.vh"

module crc8_calc (
  // Payload, left aligned, and its length in bytes
  input wire [23:0] data,
  input wire [1:0] nbytes,
  // Remainder
  output reg [7:0] crc
);

  always @* begin : calc
    integer i;
    crc = `CRC_PRESET;
    for (i = 0; i < 24; i = i + 1) begin
      // Bits enter most significant first, as they travel on the wire.
      if (i < {nbytes, 3'b000}) begin
        crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ data[23 - i]) ? `CRC_POLY : 8'h00);
      end
    end
  end

endmodule

// ===== tb/adc_ctrl_assertions.sv
// Concurrent checks on the ports of the converter control block.
`timescale 1ns/1ps
module adc_ctrl_assertions (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Watched ports
  input wire logic cs_b,
  input wire logic sdo_oe,
  input wire logic [7:0] gpio_out,
  input wire logic [7:0] gpio_oe,
  input wire logic [7:0] ain_select,
  input wire logic ref_internal_en,
  input wire logic range_double,
  input wire logic conv_start,
  input wire logic cal_start
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // Properties
  a_reset_all_analog: assert property ($rose(rst_b) |-> ain_select == 8'hFF && gpio_oe == 8'h00)
    else $error("channels not analog after reset");
  a_reset_ext_ref: assert property ($rose(rst_b) |-> !ref_internal_en && !range_double)
    else $error("reference or range not default after reset");
  a_analog_no_drive: assert property ((gpio_oe & ain_select) == 8'h00)
    else $error("analog channel is driven");
  a_open_drain_low: assert property ((gpio_out & ~gpio_oe) == 8'h00)
    else $error("pin level without drive");
  a_sdo_enable: assert property ($fell(cs_b) |-> ##[1:4] sdo_oe)
    else $error("data out not enabled in frame");
  a_sdo_release: assert property ($rose(cs_b) |-> ##[1:4] !sdo_oe)
    else $error("data out not released after frame");
  a_conv_spacing: assert property (conv_start |=> !conv_start [*8])
    else $error("conversion starts too close");
  a_cal_single: assert property (cal_start |=> !cal_start)
    else $error("calibration start longer than one cycle");
endmodule

bind adc_ctrl adc_ctrl_assertions i_chk (.clk_sys(clk_sys), .rst_b(rst_b), .cs_b(cs_b), .sdo_oe(sdo_oe),
  .gpio_out(gpio_out), .gpio_oe(gpio_oe), .ain_select(ain_select), .ref_internal_en(ref_internal_en),
  .range_double(range_double), .conv_start(conv_start), .cal_start(cal_start));

// ===== tb/adc_ctrl_bench.sv
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
`include "adc_ctrl_consts.vh"
module adc_ctrl_bench;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  wire cs_b, sclk, sdi, sdo, sdo_oe, ref_internal_en, range_double, conv_start, cal_start;
  wire [7:0] gpio_out, gpio_oe, ain_select;
  wire [2:0] conv_channel;
  logic [7:0] gpio_in = 8'h00;
  logic [15:0] conv_code = 16'h0000;
  logic conv_done = 1'b0;
  logic cal_done = 1'b0;
  logic vtest_active = 1'b0;
  logic bitwalk_active = 1'b0;
  logic chk_on = 1'b0;
  logic [7:0] ch_seen = 8'h00;
  logic [31:0] r;
  int bad_count = 0;
  int samples_checked = 0;
  int n_conv = 0;
  int cyc = 0;
  int t_last = 0;
  int cd = 0;
  int cc = 0;
  int n0;
  int t1;
  always #20 clk_sys = ~clk_sys;
  adc_ctrl i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .cs_b(cs_b), .sclk(sclk), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .ain_select(ain_select),
    .ref_internal_en(ref_internal_en), .range_double(range_double), .conv_start(conv_start),
    .conv_channel(conv_channel), .conv_code(conv_code), .conv_done(conv_done), .cal_start(cal_start),
    .cal_done(cal_done), .vtest_active(vtest_active), .bitwalk_active(bitwalk_active));
  spi_host_model i_host (.clk_sys(clk_sys), .cs_b(cs_b), .sclk(sclk), .sdi(sdi), .sdo(sdo));
  // ==========================================================
  // Front end: each conversion answers 21 cycles after its start with a code one above the last.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    conv_done <= (cd == 1);
    cal_done <= (cc == 1);
    if (cd == 1) conv_code <= conv_code + 16'h0001;
    cd <= conv_start ? 20 : (cd > 0 ? cd - 1 : 0);
    cc <= cal_start ? 500 : (cc > 0 ? cc - 1 : 0);
    if (conv_start) begin
      n_conv <= n_conv + 1;
      t_last <= cyc;
      ch_seen <= ch_seen | (8'h01 << conv_channel);
    end
  end
  // ==========================================================
  // Tasks
  task automatic cmp(input [31:0] got, input [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input [7:0] a, input [7:0] d, input bit bad = 1'b0);
    i_host.frame({`OP_WRITE, a, d}, chk_on, bad, r);
  endtask
  task automatic rd(input [7:0] a, input [7:0] m, input [7:0] e);
    i_host.frame({`OP_READ, a, 8'h00}, chk_on, 1'b0, r);
    i_host.frame(24'h000000, chk_on, 1'b0, r);
    cmp(r[31:24] & m, e);
    if (chk_on) cmp(r[23:16], i_host.crc8({r[31:24], 16'h0000}, 1));
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk_sys);
    bad_count++;
    summarize();
  end
  // ==========================================================
  // Tests
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk_sys);
    cmp(ain_select, 8'hFF);
    cmp({ref_internal_en, range_double, gpio_oe}, 10'h000);
    rd(`ADDR_GENERAL_CONTROL, 8'hFF, 8'h00);
    rd(`ADDR_CHANNEL_FUNCTION, 8'hFF, 8'h00);
    done("reset");
    wr(`ADDR_CHANNEL_FUNCTION, 8'h0F);
    wr(`ADDR_PIN_DIRECTION, 8'h03);
    wr(`ADDR_OUTPUT_DRIVE_TYPE, 8'h01);
    wr(`ADDR_PIN_OUTPUT_LEVELS, 8'h03);
    cmp({ain_select, gpio_oe, gpio_out}, 24'hF00101);
    wr(`ADDR_PIN_OUTPUT_LEVELS, 8'h00);
    cmp({gpio_oe, gpio_out}, 16'h0300);
    gpio_in <= 8'h0C;
    rd(`ADDR_PIN_INPUT_LEVELS, 8'h0C, 8'h0C);
    done("pins");
    wr(`ADDR_GENERAL_CONTROL, 8'h8A);
    cmp({ref_internal_en, range_double}, 2'b11);
    rd(`ADDR_GENERAL_CONTROL, 8'h02, 8'h02);
    rd(`ADDR_GENERAL_CONTROL, 8'hFF, 8'h88);
    done("calibration");
    // Let the conversion of the last frame finish before the code is preset.
    repeat (30) @(posedge clk_sys);
    conv_code <= 16'hFFFE;
    i_host.frame(24'h000000, 1'b0, 1'b0, r);
    repeat (60) @(posedge clk_sys);
    i_host.frame(24'h000000, 1'b0, 1'b0, r);
    cmp(r[31:8], 24'hFFFF00);
    wr(`ADDR_AVERAGING_CONTROL, 8'h02);
    wr(`ADDR_DATA_CONFIG, 8'h20);
    vtest_active <= 1'b1;
    repeat (600) @(posedge clk_sys);
    conv_code <= 16'h7FFF;
    n0 = n_conv;
    i_host.frame(24'h000000, 1'b0, 1'b0, r);
    t1 = t_last;
    repeat (700) @(posedge clk_sys);
    cmp(n_conv - n0, 4);
    cmp((t_last - t1 >= 375) && (t_last - t1 <= 380), 1);
    i_host.frame(24'h000000, 1'b0, 1'b0, r);
    cmp(r[31:8], 24'h80018C);
    done("averaging");
    wr(`ADDR_GENERAL_CONTROL, 8'h8C);
    chk_on = 1'b1;
    wr(`ADDR_AVERAGING_CONTROL, 8'h00, 1'b1);
    rd(`ADDR_SYSTEM_STATE, 8'h01, 8'h01);
    wr(`ADDR_AVERAGING_CONTROL, 8'h00);
    rd(`ADDR_AVERAGING_CONTROL, 8'h07, 8'h02);
    i_host.frame(24'h000000, 1'b1, 1'b0, r);
    cmp({r[11:8], r[7:0]}, {4'hE, i_host.crc8(r[31:8], 3)});
    wr(`ADDR_SYSTEM_STATE, 8'h01);
    rd(`ADDR_SYSTEM_STATE, 8'h01, 8'h00);
    done("check code");
    // Manual conversions so far all used channel 0; autonomous mode must add only 4 and 6.
    wr(`ADDR_SEQUENCE_CHANNEL_ENABLES, 8'h50);
    wr(`ADDR_SEQUENCE_MODE, {6'h00, `MODE_AUTONOMOUS});
    repeat (2000) @(posedge clk_sys);
    cmp(ch_seen, 8'h51);
    done("autonomous");
    summarize();
  end
endmodule

// ===== tb/spi_host_model.sv
// Behavioural serial host that frames commands for the converter control block.
`timescale 1ns/1ps
module spi_host_model (
  // Clock
  input wire logic clk_sys,
  // Serial port
  output logic cs_b,
  output logic sclk,
  output logic sdi,
  input wire logic sdo
);
  initial begin
    cs_b = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // ==========================================================
  // Check byte over nb left-aligned bytes, most significant bit first.
  function automatic [7:0] crc8(input [23:0] d, input int nb);
    logic [7:0] c;
    int i;
    c = 8'hFF;
    for (i = 23; i >= 24 - 8 * nb; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  // ==========================================================
  // One mode 0 frame; the reply comes back left aligned.
  task automatic frame(input [23:0] p, input bit chk, input bit bad, output [31:0] r);
    logic [31:0] sh;
    int i;
    int n;
    sh = {p, chk ? (crc8(p, 3) ^ {7'h00, bad}) : 8'h00};
    n = chk ? 32 : 24;
    r = 32'h0;
    @(posedge clk_sys);
    cs_b <= 1'b0;
    sdi <= sh[31];
    repeat (4) @(posedge clk_sys);
    for (i = 0; i < n; i++) begin
      sclk <= 1'b1;
      repeat (4) @(posedge clk_sys);
      r = {r[30:0], sdo};
      sh = {sh[30:0], 1'b0};
      sclk <= 1'b0;
      sdi <= sh[31];
      repeat (4) @(posedge clk_sys);
    end
    cs_b <= 1'b1;
    // A released data line must not keep its last value.
    sdi <= ~sdi;
    r = r << (32 - n);
    repeat (8) @(posedge clk_sys);
  endtask
endmodule
